// ### abac_burst_ctl.sv
// burst accumulator, power sequencing and track delay control for the converter
`timescale 1ns/1ps
module abac_burst_ctl (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  sfr_page,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic        burst_mode_en,
    input  wire logic        converter_enable,
    input  wire logic        delayed_track_sel,
    input  wire logic        soc_pulse,
    input  wire logic        sar_tick,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             conv_start,
    output logic             conv_powered,
    output logic             conv_complete,
    output logic             conv_busy,
    output logic             low_power_mode_en,
    output logic             twelve_bit_mode_en
);

    // ****************************************************
    // reset release
    // ****************************************************
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ****************************************************
    // registers and decode
    // ****************************************************
    logic [7:0]  acc_cfg_r;
    logic [4:0]  pwr_cfg_r;
    logic [5:0]  trk_cfg_r;
    logic [15:0] accum_r;
    logic [7:0]  rdata_r;

    wire on_cfg       = (sfr_page == abac_pkg::PAGE_CFG);
    wire on_burst     = (sfr_page == abac_pkg::PAGE_BURST);
    wire sel_acc_cfg  = on_cfg && (sfr_addr == abac_pkg::ADDR_ACC_CFG);
    wire sel_res_low  = on_cfg && (sfr_addr == abac_pkg::ADDR_RES_LOW);
    wire sel_res_high = on_cfg && (sfr_addr == abac_pkg::ADDR_RES_HIGH);
    wire sel_pwr_cfg  = on_burst && (sfr_addr == abac_pkg::ADDR_PWR_CFG);
    wire sel_trk_cfg  = on_burst && (sfr_addr == abac_pkg::ADDR_TRK_CFG);

    wire       twelve_bit  = acc_cfg_r[abac_pkg::TWELVE_BIT_POS];
    wire       accum_en    = acc_cfg_r[abac_pkg::ACCUM_EN_POS];
    wire [2:0] sj_sel      = acc_cfg_r[abac_pkg::SJ_MSB:abac_pkg::SJ_LSB];
    wire [2:0] rpt_sel     = acc_cfg_r[abac_pkg::RPT_MSB:abac_pkg::RPT_LSB];
    wire [3:0] pwr_field   = pwr_cfg_r[abac_pkg::PWR_MSB:abac_pkg::PWR_LSB];

    assign twelve_bit_mode_en = twelve_bit;
    assign low_power_mode_en  = pwr_cfg_r[4];

    // ****************************************************
    // result formatting
    // ****************************************************
    wire [2:0]  left_amt  = twelve_bit ? abac_pkg::LEFT_SHIFT_12 : abac_pkg::LEFT_SHIFT_10;
    wire        sj_right  = (sj_sel < abac_pkg::SJ_LEFT);
    // reserved codes fall back to the unshifted value rather than garbage
    wire [15:0] res_fmt   = sj_right ? (accum_r >> sj_sel[1:0]) :
                            (sj_sel == abac_pkg::SJ_LEFT) ? (accum_r << left_amt) :
                            accum_r;

    wire [7:0] rd_acc = {twelve_bit, 1'b0, sj_sel, rpt_sel};
    wire [7:0] rd_pwr = {pwr_cfg_r[4], 3'b000, pwr_field};
    wire [7:0] rd_trk = {2'b00, trk_cfg_r};

    wire [7:0] rd_mux = sel_acc_cfg  ? rd_acc :
                        sel_pwr_cfg  ? rd_pwr :
                        sel_trk_cfg  ? rd_trk :
                        sel_res_low  ? res_fmt[7:0] :
                        sel_res_high ? res_fmt[15:8] :
                        8'h00;

    assign sfr_rdata = rdata_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // configuration writes; unused and reserved bits are never stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_cfg_r <= abac_pkg::ACC_CFG_RST;
            pwr_cfg_r <= abac_pkg::PWR_CFG_RST;
            trk_cfg_r <= abac_pkg::TRK_CFG_RST;
        end else if (sfr_wr) begin
            if (sel_acc_cfg) begin
                acc_cfg_r <= sfr_wdata;
            end
            if (sel_pwr_cfg) begin
                pwr_cfg_r <= {sfr_wdata[abac_pkg::LPM_POS], sfr_wdata[3:0]};
            end
            if (sel_trk_cfg) begin
                trk_cfg_r <= sfr_wdata[abac_pkg::TRK_MSB:abac_pkg::TRK_LSB];
            end
        end
    end

    // ****************************************************
    // burst sequencer
    // ****************************************************
    abac_pkg::abac_state_type state_r;
    abac_pkg::abac_state_type state_nxt;

    abac_tmr_if tif ();

    abac_delay_timer u_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tif     (tif)
    );

    logic [6:0] conv_left_r;
    logic       first_r;
    logic [1:0] dtrk_cnt_r;
    logic       start_r;
    logic       complete_r;
    logic       powered_r;
    logic       busy_r;

    logic       go_conv;
    logic       start_nxt;
    logic       complete_nxt;
    logic       burst_begin;
    logic       tmr_load;
    logic       tmr_coarse;
    logic [6:0] tmr_units;

    // conversions per burst; reserved codes run a single conversion
    wire [6:0] burst_total = (rpt_sel == 3'h1) ? 7'h04 :
                             (rpt_sel == 3'h2) ? 7'h08 :
                             (rpt_sel == 3'h3) ? 7'h10 :
                             (rpt_sel == 3'h4) ? 7'h20 :
                             (rpt_sel == 3'h5) ? 7'h40 :
                             7'h01;

    wire [6:0] pwr_units   = {3'b000, pwr_field} + 7'h01;
    wire [6:0] track_units = abac_pkg::TRACK_BASE - {1'b0, trk_cfg_r};
    wire       soc_ok      = soc_pulse && (burst_mode_en || converter_enable);
    wire       sample_in   = (state_r == abac_pkg::ST_CONVERT) && conv_done;
    wire       more_left   = burst_mode_en && (conv_left_r > 7'h01);
    wire       dtrk_end    = sar_tick && (dtrk_cnt_r == abac_pkg::DTRACK_LAST);

    assign tif.load   = tmr_load;
    assign tif.coarse = tmr_coarse;
    assign tif.units  = tmr_units;

    always_comb begin
        state_nxt    = state_r;
        go_conv      = 1'b0;
        start_nxt    = 1'b0;
        complete_nxt = 1'b0;
        burst_begin  = 1'b0;
        tmr_load     = 1'b0;
        tmr_coarse   = 1'b0;
        tmr_units    = 7'h00;
        case (state_r)
            abac_pkg::ST_IDLE: begin
                if (soc_ok) begin
                    burst_begin = 1'b1;
                    if (burst_mode_en && !converter_enable) begin
                        state_nxt  = abac_pkg::ST_POWERUP;
                        tmr_load   = 1'b1;
                        tmr_coarse = 1'b1;
                        tmr_units  = pwr_units;
                    end else begin
                        go_conv = 1'b1;
                    end
                end
            end
            abac_pkg::ST_POWERUP: begin
                if (tif.done) begin
                    go_conv = 1'b1;
                end
            end
            abac_pkg::ST_TRACK: begin
                if (tif.done) begin
                    go_conv = 1'b1;
                end
            end
            abac_pkg::ST_DTRACK: begin
                if (dtrk_end) begin
                    state_nxt = abac_pkg::ST_CONVERT;
                    start_nxt = 1'b1;
                end
            end
            abac_pkg::ST_CONVERT: begin
                if (conv_done) begin
                    if (more_left) begin
                        state_nxt = abac_pkg::ST_TRACK;
                        tmr_load  = 1'b1;
                        tmr_units = track_units;
                    end else begin
                        state_nxt    = abac_pkg::ST_IDLE;
                        complete_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = abac_pkg::ST_IDLE;
            end
        endcase
        if (go_conv) begin
            if (delayed_track_sel) begin
                state_nxt = abac_pkg::ST_DTRACK;
            end else begin
                state_nxt = abac_pkg::ST_CONVERT;
                start_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= abac_pkg::ST_IDLE;
            start_r    <= 1'b0;
            complete_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            start_r    <= start_nxt;
            complete_r <= complete_nxt;
        end
    end

    // delayed-track counter restarts every time the state is entered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dtrk_cnt_r <= 2'h0;
        end else if (state_r != abac_pkg::ST_DTRACK) begin
            dtrk_cnt_r <= 2'h0;
        end else if (sar_tick) begin
            dtrk_cnt_r <= dtrk_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_left_r <= 7'h00;
            first_r     <= 1'b0;
        end else if (burst_begin) begin
            conv_left_r <= burst_mode_en ? burst_total : 7'h01;
            first_r     <= 1'b1;
        end else if (sample_in) begin
            conv_left_r <= conv_left_r - 7'h01;
            first_r     <= 1'b0;
        end
    end

    // ****************************************************
    // accumulator
    // ****************************************************
    wire [15:0] sample_ext = twelve_bit ? {4'h0, conv_data} : {6'h00, conv_data[9:0]};
    // a burst restarts the sum; single conversions keep it only when accumulating
    wire        keep_sum   = burst_mode_en ? !first_r : accum_en;
    wire [15:0] sum_nxt    = (keep_sum ? accum_r : 16'h0000) + sample_ext;

    // software writes take precedence over a sample landing in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            accum_r <= 16'h0000;
        end else if (sfr_wr && sel_res_low) begin
            accum_r[7:0] <= sfr_wdata;
        end else if (sfr_wr && sel_res_high) begin
            accum_r[15:8] <= sfr_wdata;
        end else if (sample_in) begin
            accum_r <= sum_nxt;
        end
    end

    // ****************************************************
    // power and status
    // ****************************************************
    // outside burst the delay settings never touch power
    wire powered_nxt = burst_mode_en ?
                       (converter_enable || (state_nxt != abac_pkg::ST_IDLE)) :
                       converter_enable;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powered_r <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            powered_r <= powered_nxt;
            busy_r    <= (state_nxt != abac_pkg::ST_IDLE);
        end
    end

    assign conv_start    = start_r;
    assign conv_complete = complete_r;
    assign conv_powered  = powered_r;
    assign conv_busy     = busy_r;

endmodule

// ### abac_pkg.sv
// constants shared by the burst accumulator control block
package abac_pkg;

    // ****************************************************
    // register page and address map
    // ****************************************************
    localparam logic [7:0] PAGE_CFG      = 8'h00;
    localparam logic [7:0] PAGE_BURST    = 8'h0F;
    localparam logic [7:0] ADDR_ACC_CFG  = 8'hBA;
    localparam logic [7:0] ADDR_PWR_CFG  = 8'hBA;
    localparam logic [7:0] ADDR_TRK_CFG  = 8'hBD;
    localparam logic [7:0] ADDR_RES_LOW  = 8'hBD;
    localparam logic [7:0] ADDR_RES_HIGH = 8'hBE;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int TWELVE_BIT_POS = 7;
    localparam int ACCUM_EN_POS   = 6;
    localparam int SJ_LSB         = 3;
    localparam int SJ_MSB         = 5;
    localparam int RPT_LSB        = 0;
    localparam int RPT_MSB        = 2;
    localparam int LPM_POS        = 7;
    localparam int PWR_LSB        = 0;
    localparam int PWR_MSB        = 3;
    localparam int TRK_LSB        = 0;
    localparam int TRK_MSB        = 5;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    localparam logic [4:0] PWR_CFG_RST = 5'h0F;
    localparam logic [5:0] TRK_CFG_RST = 6'h1E;

    // ****************************************************
    // codes and formatting
    // ****************************************************
    localparam logic [2:0] SJ_LEFT        = 3'h4;
    localparam logic [2:0] LEFT_SHIFT_10  = 3'h6;
    localparam logic [2:0] LEFT_SHIFT_12  = 3'h4;
    localparam logic [6:0] TRACK_BASE     = 7'h40;
    localparam logic [1:0] DTRACK_LAST    = 2'h2;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int TRACK_STEP_NS    = 50;
    localparam int POWERUP_STEP_NS  = 400;
    localparam int TRACK_STEP_CYC   = (TRACK_STEP_NS * 1000) / CLK_PERIOD_PS;
    localparam int POWERUP_STEP_CYC = (POWERUP_STEP_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_POWERUP = 3'b001,
        ST_TRACK   = 3'b010,
        ST_DTRACK  = 3'b011,
        ST_CONVERT = 3'b100
    } abac_state_type;

endpackage

// ### abac_tmr_if.sv
// interface between the sequencer and its delay timer
`timescale 1ns/1ps
interface abac_tmr_if;
    logic       load;
    logic       coarse;
    logic [6:0] units;
    logic       done;

    modport ctl (output load, output coarse, output units, input done);
    modport tmr (input load, input coarse, input units, output done);
endinterface

// ### abac_delay_timer.sv
// delay timer counting 50 ns or 400 ns steps of the system clock
`timescale 1ns/1ps
module abac_delay_timer (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    abac_tmr_if.tmr    tif
);

    localparam logic [6:0] FINE_LAST   = 7'(abac_pkg::TRACK_STEP_CYC - 1);
    localparam logic [6:0] COARSE_LAST = 7'(abac_pkg::POWERUP_STEP_CYC - 1);

    logic       busy_r;
    logic       coarse_r;
    logic [6:0] pre_r;
    logic [6:0] cnt_r;
    logic       done_r;
    wire  [6:0] step_last;
    wire        step_end;

    assign step_last = coarse_r ? COARSE_LAST : FINE_LAST;
    assign step_end  = busy_r && (pre_r == 7'h00);
    assign tif.done  = done_r;

    // delay is units times one step; done pulses for one cycle at the end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_r   <= 1'b0;
            coarse_r <= 1'b0;
            pre_r    <= 7'h00;
            cnt_r    <= 7'h00;
            done_r   <= 1'b0;
        end else if (tif.load) begin
            busy_r   <= 1'b1;
            coarse_r <= tif.coarse;
            pre_r    <= tif.coarse ? COARSE_LAST : FINE_LAST;
            cnt_r    <= tif.units;
            done_r   <= 1'b0;
        end else begin
            done_r <= step_end && (cnt_r == 7'h01);
            if (step_end) begin
                pre_r  <= step_last;
                cnt_r  <= cnt_r - 7'h01;
                busy_r <= (cnt_r != 7'h01);
            end else if (busy_r) begin
                pre_r <= pre_r - 7'h01;
            end
        end
    end

endmodule

// ### abac_checker.sv
// port-level assertions for the burst accumulator control block
`timescale 1ns/1ps
module abac_checker (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [7:0]  sfr_page,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        burst_mode_en,
    input wire logic        converter_enable,
    input wire logic        delayed_track_sel,
    input wire logic        soc_pulse,
    input wire logic        sar_tick,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    input wire logic        conv_start,
    input wire logic        conv_powered,
    input wire logic        conv_complete,
    input wire logic        conv_busy,
    input wire logic        low_power_mode_en,
    input wire logic        twelve_bit_mode_en
);
    // ****************************************************
    // decodes and assertions
    // ****************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    wire pg0    = sfr_page == abac_pkg::PAGE_CFG;
    wire pgf    = sfr_page == abac_pkg::PAGE_BURST;
    wire at_acc = pg0 && sfr_addr == abac_pkg::ADDR_ACC_CFG;
    wire at_pwr = pgf && sfr_addr == abac_pkg::ADDR_PWR_CFG;
    wire at_trk = pgf && sfr_addr == abac_pkg::ADDR_TRK_CFG;
    // a start request the sequencer must take without any tracking wait
    wire soc_go = soc_pulse && !conv_busy && !delayed_track_sel;

    a_single_start: assert property (soc_go && converter_enable && !burst_mode_en |=> conv_start)
        else $error("single conversion did not start next cycle");
    a_burst_start: assert property (soc_go && converter_enable && burst_mode_en |=> conv_start)
        else $error("powered burst did not start next cycle");
    a_powerup_wait: assert property (soc_pulse && !conv_busy && burst_mode_en && !converter_enable
        |=> !conv_start [*8])
        else $error("burst started before power-up delay");
    a_drop_power: assert property (burst_mode_en && !converter_enable && conv_complete
        |-> ##[0:2] !conv_powered)
        else $error("converter stayed powered after burst");
    a_stay_powered: assert property (burst_mode_en && converter_enable && conv_complete
        |-> conv_powered ##1 conv_powered)
        else $error("converter lost power after burst");
    a_power_follow: assert property (!burst_mode_en && $stable(burst_mode_en) && !conv_busy
        && $stable(converter_enable) |-> conv_powered == converter_enable)
        else $error("power state differs from converter enable");
    a_done_complete: assert property (conv_complete |-> $past(conv_done) && !conv_busy)
        else $error("completion without preceding conversion end");
    a_complete_pulse: assert property (conv_complete |=> !conv_complete)
        else $error("completion longer than one cycle");
    a_twelve_set: assert property ($rose(twelve_bit_mode_en)
        |-> $past(sfr_wr && at_acc && sfr_wdata[7]))
        else $error("twelve-bit mode set without write");
    a_lpm_set: assert property ($rose(low_power_mode_en)
        |-> $past(sfr_wr && at_pwr && sfr_wdata[7]))
        else $error("low-power mode set without write");
    a_acc_bit6: assert property (sfr_rd && at_acc |=> !sfr_rdata[6])
        else $error("accumulate enable read back nonzero");
    a_pwr_unused: assert property (sfr_rd && at_pwr |=> sfr_rdata[6:4] == 3'h0)
        else $error("power-up unused bits read nonzero");
    a_trk_rsvd: assert property (sfr_rd && at_trk |=> sfr_rdata[7:6] == 2'h0)
        else $error("track reserved bits read nonzero");
endmodule

bind abac_burst_ctl abac_checker chk_i (
    .clk_sys(clk_sys), .nrst(nrst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .burst_mode_en(burst_mode_en), .converter_enable(converter_enable),
    .delayed_track_sel(delayed_track_sel), .soc_pulse(soc_pulse), .sar_tick(sar_tick),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .conv_powered(conv_powered), .conv_complete(conv_complete), .conv_busy(conv_busy),
    .low_power_mode_en(low_power_mode_en), .twelve_bit_mode_en(twelve_bit_mode_en)
);

// ### tb.sv
// self-checking testbench for the burst accumulator control block
`timescale 1ns/1ps
module tb;
    logic        clk_sys, nrst, sfr_wr, sfr_rd, soc_pulse, sar_tick, conv_done;
    logic        burst_mode_en, converter_enable, delayed_track_sel;
    logic        conv_start, conv_powered, conv_complete, conv_busy;
    logic        low_power_mode_en, twelve_bit_mode_en;
    logic [7:0]  sfr_page, sfr_addr, sfr_wdata, sfr_rdata, b;
    logic [11:0] conv_data;
    logic [15:0] r;
    logic [1:0]  tick_cnt = 2'h0;
    int          errors, n_checks, ns, lat, gap, i, f, n;
    localparam logic [7:0] PG0 = abac_pkg::PAGE_CFG, PGF = abac_pkg::PAGE_BURST,
        A_ACC = abac_pkg::ADDR_ACC_CFG, A_PWR = abac_pkg::ADDR_PWR_CFG,
        A_TRK = abac_pkg::ADDR_TRK_CFG, A_RL = abac_pkg::ADDR_RES_LOW,
        A_RH = abac_pkg::ADDR_RES_HIGH;

    abac_burst_ctl dut (.clk_sys(clk_sys), .nrst(nrst), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .burst_mode_en(burst_mode_en),
        .converter_enable(converter_enable), .delayed_track_sel(delayed_track_sel),
        .soc_pulse(soc_pulse), .sar_tick(sar_tick), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .conv_powered(conv_powered),
        .conv_complete(conv_complete), .conv_busy(conv_busy),
        .low_power_mode_en(low_power_mode_en), .twelve_bit_mode_en(twelve_bit_mode_en));

    // ****************************************************
    // clock, conversion clock ticks and watchdog
    // ****************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // one conversion-clock tick every fourth system clock
    always @(posedge clk_sys) begin
        tick_cnt <= tick_cnt + 2'h1;
        sar_tick <= (tick_cnt == 2'h3);
    end

    // the longest run is a few thousand cycles; this is ample slack
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        end_sim();
    end

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_page <= pg;
        sfr_addr <= ad;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_page <= pg;
        sfr_addr <= ad;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(negedge clk_sys);
        d = sfr_rdata;
    endtask

    task automatic rres(output logic [15:0] v);
        rd(PG0, A_RL, v[7:0]);
        rd(PG0, A_RH, v[15:8]);
    endtask

    // one start request; each conv_start is answered by conv_done two edges later
    task automatic run(input logic [11:0] d, output int starts, output int lat1, output int g);
        int t;
        int since;
        logic fire;
        starts = 0;
        lat1 = -1;
        g = -1;
        since = -1;
        @(posedge clk_sys);
        conv_data <= d;
        soc_pulse <= 1'b1;
        @(posedge clk_sys);
        soc_pulse <= 1'b0;
        for (t = 0; t < 20000; t++) begin
            @(negedge clk_sys);
            if (conv_complete === 1'b1)
                break;
            fire = (conv_start === 1'b1);
            if (fire) begin
                starts++;
                if (starts == 1)
                    lat1 = t;
                else
                    g = since;
            end else if (since >= 0) begin
                since++;
            end
            @(posedge clk_sys);
            conv_done <= fire;
            if (fire)
                since = 0;
        end
        chk("done_seen", 16'(t < 20000), 16'h1);
    endtask

    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        {nrst, sfr_wr, sfr_rd, soc_pulse, conv_done} = 5'h00;
        {burst_mode_en, converter_enable, delayed_track_sel} = 3'h0;
        {sfr_page, sfr_addr, sfr_wdata} = 24'h0;
        conv_data = 12'h000;
        errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);

        rd(PG0, A_ACC, b);
        chk("acc_rst", 16'(b), 16'h0);
        rd(PGF, A_PWR, b);
        chk("pwr_rst", 16'(b), 16'h000F);
        rd(PGF, A_TRK, b);
        chk("trk_rst", 16'(b), 16'h001E);
        rres(r);
        chk("res_rst", r, 16'h0);

        wr(PG0, A_ACC, 8'hC0);
        rd(PG0, A_ACC, b);
        chk("acc_rd", 16'(b), 16'h0080);
        chk("twelve", 16'(twelve_bit_mode_en), 16'h1);
        wr(PGF, A_PWR, 8'hF4);
        rd(PGF, A_PWR, b);
        chk("pwr_rd", 16'(b), 16'h0084);
        chk("lpm", 16'(low_power_mode_en), 16'h1);
        wr(PGF, A_TRK, 8'h3F);
        rd(PGF, A_TRK, b);
        chk("trk_rd", 16'(b), 16'h003F);
        rd(PGF, A_RH, b);
        chk("unmapped", 16'(b), 16'h0);
        wr(PG0, A_ACC, 8'h00);
        chk("twelve_off", 16'(twelve_bit_mode_en), 16'h0);

        @(posedge clk_sys);
        converter_enable <= 1'b1;
        run(12'h155, ns, lat, gap);
        chk("single_n", 16'(ns), 16'h1);
        chk("single_lat", 16'(lat), 16'h0);
        rres(r);
        chk("latest", r, 16'h0155);
        wr(PG0, A_ACC, 8'h40);
        wr(PG0, A_RL, 8'h00);
        wr(PG0, A_RH, 8'h00);
        rres(r);
        chk("cleared", r, 16'h0);
        run(12'h0AB, ns, lat, gap);
        run(12'h0AB, ns, lat, gap);
        rres(r);
        chk("acc_sum", r, 16'h0156);
        rd(PG0, A_ACC, b);
        chk("ae_rd", 16'(b), 16'h0);

        wr(PG0, A_RL, 8'h23);
        wr(PG0, A_RH, 8'h01);
        for (i = 0; i < 4; i++) begin
            wr(PG0, A_ACC, {2'b00, 3'(i), 3'b000});
            rres(r);
            chk("sj_right", r, 16'h0123 >> i);
        end
        wr(PG0, A_ACC, 8'h30);
        rres(r);
        chk("sj_rsvd", r, 16'h0123);
        wr(PG0, A_ACC, 8'hA0);
        rres(r);
        chk("sj_left12", r, 16'h1230);
        wr(PG0, A_ACC, 8'h20);
        rres(r);
        chk("sj_left10", r, 16'h48C0);

        @(posedge clk_sys);
        burst_mode_en <= 1'b1;
        for (i = 0; i < 6; i++) begin
            f = 63 - (i % 2);
            n = (i == 0) ? 1 : (2 << i);
            wr(PGF, A_TRK, 8'(f));
            wr(PG0, A_ACC, {5'h00, 3'(i)});
            run(12'h003, ns, lat, gap);
            chk("rpt_n", 16'(ns), 16'(n));
            chk("burst_lat", 16'(lat), 16'h0);
            if (n > 1)
                chk("trk_gap", 16'(gap >= 10*(64-f) && gap <= 10*(64-f)+2), 16'h1);
            rres(r);
            chk("burst_sum", r, 16'(3 * n));
            chk("stay_pwr", 16'(conv_powered), 16'h1);
        end

        @(posedge clk_sys);
        converter_enable <= 1'b0;
        wr(PGF, A_TRK, 8'h00);
        wr(PGF, A_PWR, 8'h00);
        wr(PG0, A_ACC, 8'h01);
        run(12'h001, ns, lat, gap);
        chk("pwr0_lat", 16'(lat >= 80 && lat <= 83), 16'h1);
        chk("trk0_gap", 16'(gap >= 640 && gap <= 642), 16'h1);
        repeat (3) @(posedge clk_sys);
        chk("low_pwr", 16'(conv_powered), 16'h0);
        wr(PGF, A_PWR, 8'h04);
        run(12'h001, ns, lat, gap);
        chk("pwr4_lat", 16'(lat >= 400 && lat <= 403), 16'h1);

        wr(PG0, A_ACC, 8'h00);
        @(posedge clk_sys);
        burst_mode_en <= 1'b0;
        converter_enable <= 1'b1;
        delayed_track_sel <= 1'b1;
        run(12'h001, ns, lat, gap);
        chk("dtrk_n", 16'(ns), 16'h0001);
        chk("dtrk_lat", 16'(lat >= 8 && lat <= 14), 16'h1);
        end_sim();
    end
endmodule
